// [design/csc_counter_access.sv]
/*
  indirect host access to the 24-bit cell statistics counters, plus the
  per-counter event increment path and per-link overflow flags.
  assumes: host strobes are one-cycle pulses synchronous to mclk.
*/
`timescale 1ns/10ps
module csc_counter_access #(
  parameter int LINKS = csc_pkg::LINKS
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire csc_pkg::csc_host_req_type host_req,
  output logic [7:0]                    host_rdata,
  input  wire csc_pkg::csc_event_type    cell_event,
  output logic                          event_ready,
  output logic [LINKS-1:0]              link_overflow,
  output logic [LINKS-1:0]              link_overflow_irq_en
);

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_EVT} csc_state_type;

  // -------------------------------------------------------------------
  // host registers
  // -------------------------------------------------------------------
  csc_state_type state;
  csc_state_type next_state;
  logic [7:0]  stage_high;
  logic [7:0]  stage_mid;
  logic [7:0]  stage_low;
  logic [7:0]  selector;
  logic [23:0] result;
  logic [6:0]  ctrl;
  logic        done;
  logic        pending;
  logic        next_pending;
  logic [23:0] xfer_value;
  logic [7:0]  xfer_sel;
  logic [6:0]  xfer_ctrl;
  logic [7:0]  evt_sel;
  logic        ctrl_wr;
  logic        start_cmd;
  logic [7:0]  mem_addr;
  logic        mem_we;
  logic [24:0] mem_wdata;
  logic [24:0] mem_rdata;
  logic        xfer_valid_cmd;
  logic        xfer_is_write;

  assign ctrl_wr   = host_req.wr && host_req.addr == csc_pkg::ADDR_CTRL;
  assign start_cmd = ctrl_wr && (host_req.wdata[1:0] == csc_pkg::CMD_VALUE ||
                     host_req.wdata[1:0] == csc_pkg::CMD_ENABLE);
  assign xfer_valid_cmd = xfer_ctrl[1:0] == csc_pkg::CMD_VALUE ||
                          xfer_ctrl[1:0] == csc_pkg::CMD_ENABLE;
  assign xfer_is_write  = xfer_ctrl[csc_pkg::CTRL_DIR_BIT] ==
                          csc_pkg::DIR_WRITE;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage_high <= csc_pkg::RST_BYTE;
      stage_mid  <= csc_pkg::RST_BYTE;
      stage_low  <= csc_pkg::RST_BYTE;
      selector   <= csc_pkg::RST_BYTE;
    end else if (host_req.wr) begin
      case (host_req.addr)
        csc_pkg::ADDR_HIGH: stage_high <= host_req.wdata;
        csc_pkg::ADDR_MID:  stage_mid  <= host_req.wdata;
        csc_pkg::ADDR_LOW:  stage_low  <= host_req.wdata;
        csc_pkg::ADDR_SEL:  selector   <= host_req.wdata;
        default: ;
      endcase
    end
  end

  // reserved bits 6:4 are stored as written; bit 7 written value ignored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 7'h00;
    end else if (ctrl_wr) begin
      ctrl <= host_req.wdata[6:0];
    end else if (state == ST_XFER && xfer_valid_cmd && !xfer_is_write &&
                 xfer_ctrl[1:0] == csc_pkg::CMD_ENABLE) begin
      ctrl[csc_pkg::CTRL_IE_BIT] <= mem_rdata[csc_pkg::CNT_W];
    end
  end

  // done drops on a new command and rises when the transfer ends
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'h0;
    end else if (start_cmd) begin
      done <= 1'h0;
    end else if (state == ST_XFER) begin
      done <= 1'h1;
    end else if (ctrl_wr && !pending) begin
      done <= 1'h1;
    end
  end

  // snapshot of staged bytes, selector and command at issue time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_value <= 24'h000000;
      xfer_sel   <= csc_pkg::RST_BYTE;
      xfer_ctrl  <= 7'h00;
    end else if (start_cmd) begin
      xfer_value <= {stage_high, stage_mid, stage_low};
      xfer_sel   <= selector;
      xfer_ctrl  <= host_req.wdata[6:0];
    end
  end

  always_comb begin
    next_pending = pending;
    if (state == ST_IDLE && pending) begin
      next_pending = 1'h0;
    end
    if (start_cmd) begin
      next_pending = 1'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'h0;
    end else begin
      pending <= next_pending;
    end
  end

  // -------------------------------------------------------------------
  // access sequencer
  // -------------------------------------------------------------------
  always_comb begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE: begin
        if (pending) begin
          next_state = ST_XFER;
        end else if (cell_event.valid && event_ready) begin
          next_state = ST_EVT;
        end
      end
      ST_XFER: next_state = ST_IDLE;
      ST_EVT:  next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      event_ready <= 1'h0;
    end else begin
      event_ready <= next_state == ST_IDLE && !next_pending;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_sel <= csc_pkg::RST_BYTE;
    end else if (state == ST_IDLE && !pending && cell_event.valid &&
                 event_ready) begin
      evt_sel <= {cell_event.ctype, cell_event.index};
    end
  end

  // address is {type, index}: group and link codes map directly
  always_comb begin
    mem_addr  = xfer_sel;
    mem_we    = 1'h0;
    mem_wdata = mem_rdata;
    case (state)
      ST_IDLE: begin
        if (!pending) begin
          mem_addr = {cell_event.ctype, cell_event.index};
        end
      end
      ST_XFER: begin
        if (xfer_valid_cmd && xfer_is_write) begin
          mem_we = 1'h1;
          if (xfer_ctrl[1:0] == csc_pkg::CMD_VALUE) begin
            mem_wdata[csc_pkg::CNT_W-1:0] = xfer_value;
          end else begin
            mem_wdata[csc_pkg::CNT_W] =
              xfer_ctrl[csc_pkg::CTRL_IE_BIT];
          end
        end
      end
      ST_EVT: begin
        mem_addr = evt_sel;
        mem_we   = 1'h1;
        mem_wdata[csc_pkg::CNT_W-1:0] =
          mem_rdata[csc_pkg::CNT_W-1:0] + csc_pkg::CNT_ONE;
      end
      default: ;
    endcase
  end

  csc_store #(
    .WIDTH  (csc_pkg::CNT_W + 1),
    .ADDR_W (csc_pkg::SEL_W)
  ) u_store (
    .mclk  (mclk),
    .addr  (mem_addr),
    .we    (mem_we),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 24'h000000;
    end else if (state == ST_XFER && xfer_valid_cmd && !xfer_is_write &&
                 xfer_ctrl[1:0] == csc_pkg::CMD_VALUE) begin
      result <= mem_rdata[csc_pkg::CNT_W-1:0];
    end
  end

  // -------------------------------------------------------------------
  // per-link overflow flags and their interrupt enables
  // -------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LINKS; g++) begin : g_link
      logic set_ovf;
      logic clr_ovf;
      assign set_ovf = state == ST_EVT && evt_sel[3:0] == 4'(g) &&
                       mem_rdata[csc_pkg::CNT_W-1:0] == csc_pkg::CNT_MAX;
      assign clr_ovf = state == ST_XFER && xfer_valid_cmd &&
                       xfer_sel[3:0] == 4'(g);
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          link_overflow[g] <= 1'h0;
        end else if (set_ovf) begin
          link_overflow[g] <= 1'h1;
        end else if (clr_ovf) begin
          link_overflow[g] <= 1'h0;
        end
      end
      // enable shadow follows enable writes for this link's counters
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          link_overflow_irq_en[g] <= 1'h0;
        end else if (clr_ovf && xfer_is_write &&
                     xfer_ctrl[1:0] == csc_pkg::CMD_ENABLE) begin
          link_overflow_irq_en[g] <=
            xfer_ctrl[csc_pkg::CTRL_IE_BIT];
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------
  // host read data
  // -------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= csc_pkg::RST_BYTE;
    end else if (host_req.rd) begin
      case (host_req.addr)
        csc_pkg::ADDR_CTRL: host_rdata <= {done, ctrl};
        csc_pkg::ADDR_HIGH: host_rdata <= result[23:16];
        csc_pkg::ADDR_MID:  host_rdata <= result[15:8];
        csc_pkg::ADDR_LOW:  host_rdata <= result[7:0];
        csc_pkg::ADDR_SEL:  host_rdata <= selector;
        default:            host_rdata <= csc_pkg::RST_BYTE;
      endcase
    end
  end

endmodule : csc_counter_access

// [design/csc_pkg.sv]
/*
  constants, field layouts and carrier types for the statistics counter
  indirect access block.
  assumes: one 100 MHz system clock, 8-bit host port with byte addresses.
*/
// Behaviour
// - reading high byte gives counter byte three; writing stages it for write transfer
// - reading middle byte gives counter byte two; writing stages it for loading
// - reading low byte gives counter byte one; writing stages the low byte
// - staged bytes and selector are sampled only when a transfer is commanded
// - selector bits 7:4 codes 1011..1000 pick input-side all/idle/unassigned/hec counters
// - type codes 0111..0100 pick transmit total/idle/stuff/control-protocol counters
// - type codes 0011..0000 pick receive total/idle/hec-error/bad-control counters
// - for input-side types, index 1011..1000 address groups three down to zero
// - for link counters, index 0111..0000 address links seven down to zero
// - software writes command bit 7 as zero; it reads one once transfer is done
// - command bit 2 selects direction of the transfer
// - command 01 moves counter value, 10 moves interrupt enable; 00, 11 unused
// - command bit 3 is the enable value, moved only with command 10
// - link overflow flag clears only by a transfer touching that link's counter
package csc_pkg;

  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 8;
  localparam int CNT_W    = 24;
  localparam int SEL_W    = 8;
  localparam int LINKS    = 8;

  // register byte addresses
  localparam logic [9:0] ADDR_CTRL = 10'h207;
  localparam logic [9:0] ADDR_HIGH = 10'h214;
  localparam logic [9:0] ADDR_MID  = 10'h215;
  localparam logic [9:0] ADDR_LOW  = 10'h216;
  localparam logic [9:0] ADDR_SEL  = 10'h217;

  // command register fields
  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_IE_BIT   = 3;
  localparam int CTRL_DIR_BIT  = 2;
  localparam logic [1:0] CMD_VALUE  = 2'h1;
  localparam logic [1:0] CMD_ENABLE = 2'h2;
  localparam logic       DIR_WRITE  = 1'h1;

  // selector type and index codes
  localparam logic [3:0] TYPE_IN_ALL    = 4'hb;
  localparam logic [3:0] TYPE_IN_IDLE   = 4'ha;
  localparam logic [3:0] TYPE_IN_UNASG  = 4'h9;
  localparam logic [3:0] TYPE_IN_HEC    = 4'h8;
  localparam logic [3:0] TYPE_TX_TOTAL  = 4'h7;
  localparam logic [3:0] TYPE_TX_IDLE   = 4'h6;
  localparam logic [3:0] TYPE_TX_STUFF  = 4'h5;
  localparam logic [3:0] TYPE_TX_CTRL   = 4'h4;
  localparam logic [3:0] TYPE_RX_TOTAL  = 4'h3;
  localparam logic [3:0] TYPE_RX_IDLE   = 4'h2;
  localparam logic [3:0] TYPE_RX_HEC    = 4'h1;
  localparam logic [3:0] TYPE_RX_BADCTL = 4'h0;
  localparam logic [3:0] IDX_GROUP0     = 4'h8;
  localparam logic [3:0] IDX_GROUP3     = 4'hb;
  localparam logic [3:0] IDX_LINK0      = 4'h0;
  localparam logic [3:0] IDX_LINK7      = 4'h7;

  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [23:0] CNT_MAX  = 24'hffffff;
  localparam logic [23:0] CNT_ONE  = 24'h000001;

  typedef struct packed {
    logic [9:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } csc_host_req_type;

  typedef struct packed {
    logic       valid;
    logic [3:0] ctype;
    logic [3:0] index;
  } csc_event_type;

endpackage : csc_pkg

// [design/csc_store.sv]
/*
  single-port storage for counter values and their interrupt enables.
  assumes: one access per cycle; read data come out of a register.
*/
`timescale 1ns/10ps
module csc_store #(
  parameter int WIDTH  = 25,
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              we,
  input  wire logic [WIDTH-1:0]  wdata,
  output logic      [WIDTH-1:0]  rdata
);

  logic [WIDTH-1:0] mem [2**ADDR_W];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : csc_store

// [dv/csc_asserts.sv]
/*
  checker for the statistics counter indirect access block.
  assumes: bound to csc_counter_access, one clock, async low reset.
*/
`timescale 1ns/10ps
module csc_asserts #(
  parameter int LINKS = 8
) (
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire csc_pkg::csc_host_req_type host_req,
  input wire logic [7:0]                host_rdata,
  input wire csc_pkg::csc_event_type    cell_event,
  input wire logic                      event_ready,
  input wire logic [LINKS-1:0]          link_overflow,
  input wire logic [LINKS-1:0]          link_overflow_irq_en
);
  logic       cmd;
  logic       map;
  logic       tk;
  logic [2:0] since_cmd;
  logic [2:0] since_evt;
  // ----------
  // helpers
  // ----------
  assign cmd = host_req.wr && host_req.addr == csc_pkg::ADDR_CTRL
               && ^host_req.wdata[1:0];
  assign map = host_req.addr == csc_pkg::ADDR_CTRL
               || (host_req.addr >= csc_pkg::ADDR_HIGH
               && host_req.addr <= csc_pkg::ADDR_SEL);
  assign tk = cell_event.valid && event_ready;
  // saturating ages of the last command and the last taken event
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      since_cmd <= 3'h7;
    end else begin
      since_cmd <= cmd ? 3'h0 : since_cmd + {2'h0, since_cmd != 3'h7};
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      since_evt <= 3'h7;
    end else begin
      since_evt <= tk ? 3'h0 : since_evt + {2'h0, since_evt != 3'h7};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_rdata_hold: assert property (
    !host_req.rd |=> $stable(host_rdata)) else $error("read data moved");
  chk_unmapped_zero: assert property (
    host_req.rd && !map |=> host_rdata == 8'h00) else $error("bad read");
  chk_cmd_busy: assert property (
    cmd |=> !event_ready ##[1:3] event_ready) else $error("transfer time");
  chk_evt_busy: assert property (
    tk |=> !event_ready ##1 (event_ready || $past(cmd) || $past(cmd, 2)))
    else $error("event update window");
  chk_refused_idle: assert property (
    host_req.wr && host_req.addr == csc_pkg::ADDR_CTRL
    && !(^host_req.wdata[1:0]) && event_ready && !cell_event.valid
    |=> event_ready) else $error("refused command started");
  chk_en_after_cmd: assert property (
    $changed(link_overflow_irq_en) |-> since_cmd <= 3'h4)
    else $error("enable moved without command");
  chk_ovf_clear: assert property (
    |(~link_overflow & $past(link_overflow)) |-> since_cmd <= 3'h4)
    else $error("overflow cleared without transfer");
  chk_ovf_set: assert property (
    |(link_overflow & ~$past(link_overflow)) |-> since_evt <= 3'h4)
    else $error("overflow set without event");
  cover property (cmd);
  cover property (tk);
  cover property ($rose(|link_overflow));
endmodule : csc_asserts

bind csc_counter_access csc_asserts #(.LINKS(LINKS)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .host_req(host_req),
  .host_rdata(host_rdata), .cell_event(cell_event),
  .event_ready(event_ready), .link_overflow(link_overflow),
  .link_overflow_irq_en(link_overflow_irq_en));

// [dv/test_cell_stats_counter_access.sv]
/*
  self-checking bench for the counter access block over its host and event ports.
  assumes: design package compiled first, checker bound separately.
*/
`timescale 1ns/10ps
module test_cell_stats_counter_access;
  logic                      mclk = 1'b0;
  logic                      rst_n = 1'b0;
  csc_pkg::csc_host_req_type hreq = '0;
  csc_pkg::csc_event_type    evt = '0;
  logic [7:0]                rdata;
  logic                      event_ready;
  logic [7:0]                ovf;
  logic [7:0]                ien;
  logic [7:0]                rv;
  int                        err_total = 0;
  int                        n_checks = 0;

  always #5 mclk = ~mclk;

  csc_counter_access u_dut (.mclk(mclk), .rst_n(rst_n), .host_req(hreq),
    .host_rdata(rdata), .cell_event(evt), .event_ready(event_ready),
    .link_overflow(ovf), .link_overflow_irq_en(ien));

  // ----------
  // tasks
  // ----------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    hreq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk) #1;
    hreq.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge mclk) #1;
    hreq = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk) #1;
    hreq.rd = 1'b0;
    rv = rdata;
  endtask : rd
  task automatic poll;
    rv = 8'h00;
    for (int i = 0; i < 8 && rv[7] !== 1'b1; i++) rd(csc_pkg::ADDR_CTRL);
    check(rv & 8'h80, 8'h80);
  endtask : poll
  task automatic xfer(input logic [7:0] sel, input logic [7:0] c);
    wr(csc_pkg::ADDR_SEL, sel);
    wr(csc_pkg::ADDR_CTRL, c);
    poll();
  endtask : xfer
  task automatic put(input logic [7:0] sel, input logic [23:0] v);
    wr(csc_pkg::ADDR_HIGH, v[23:16]);
    wr(csc_pkg::ADDR_MID, v[15:8]);
    wr(csc_pkg::ADDR_LOW, v[7:0]);
    xfer(sel, 8'h05);
  endtask : put
  task automatic get(input logic [7:0] sel, input logic [23:0] e);
    xfer(sel, 8'h01);
    rd(csc_pkg::ADDR_HIGH);
    check(rv, e[23:16]);
    rd(csc_pkg::ADDR_MID);
    check(rv, e[15:8]);
    rd(csc_pkg::ADDR_LOW);
    check(rv, e[7:0]);
  endtask : get
  task automatic bump(input logic [7:0] sel);
    @(posedge mclk) #1;
    evt = '{valid: 1'b1, ctype: sel[7:4], index: sel[3:0]};
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      if (event_ready === 1'b1) break;
    end
    #1 evt.valid = 1'b0;
    repeat (4) @(posedge mclk);
  endtask : bump
  function automatic logic [7:0] sel_of(input logic [3:0] t);
    return {t, t < 4'h8 ? t : {2'b10, t[1:0]}};
  endfunction : sel_of
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // ----------
  // tests
  // ----------
  initial begin
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    rd(csc_pkg::ADDR_HIGH);
    check(rv, 8'h00);
    rd(csc_pkg::ADDR_LOW);
    check(rv, 8'h00);
    rd(csc_pkg::ADDR_CTRL);
    check(rv & 8'h9f, 8'h00);
    rd(10'h218);
    check(rv, 8'h00);
    for (int t = 0; t < 12; t++) begin
      put(sel_of(t[3:0]), {t[7:0], 8'h5a, ~t[7:0]});
    end
    for (int t = 0; t < 12; t++) begin
      get(sel_of(t[3:0]), {t[7:0], 8'h5a, ~t[7:0]});
    end
    wr(csc_pkg::ADDR_HIGH, 8'h11);
    wr(csc_pkg::ADDR_MID, 8'h22);
    wr(csc_pkg::ADDR_LOW, 8'h33);
    wr(csc_pkg::ADDR_SEL, 8'h72);
    wr(csc_pkg::ADDR_CTRL, 8'h05);
    wr(csc_pkg::ADDR_HIGH, 8'hee);
    wr(csc_pkg::ADDR_SEL, 8'h33);
    poll();
    get(8'h72, 24'h112233);
    get(8'h33, 24'h035afc);
    rd(csc_pkg::ADDR_SEL);
    check(rv, 8'h33);
    put(8'h73, 24'hffffff);
    check(ovf, 8'h00);
    bump(8'h73);
    check(ovf, 8'h08);
    bump(8'h55);
    get(8'h55, 24'h055afb);
    check(ovf, 8'h08);
    get(8'h73, 24'h000000);
    check(ovf, 8'h00);
    xfer(8'h76, 8'h0e);
    check(ien, 8'h40);
    xfer(8'h76, 8'h02);
    check(rv & 8'h08, 8'h08);
    xfer(8'h76, 8'h0d);
    check(ien, 8'h40);
    xfer(8'h76, 8'h06);
    check(ien, 8'h00);
    foreach (rv[i]) if (i < 2) begin
      wr(csc_pkg::ADDR_CTRL, i ? 8'h07 : 8'h04);
      rd(csc_pkg::ADDR_CTRL);
      check(rv & 8'h80, 8'h80);
    end
    get(8'h55, 24'h055afb);
    results();
  end

  initial begin
    #60000;
    err_total++;
    results();
  end
endmodule : test_cell_stats_counter_access
